//--- rtl/qec_consts.vh
// Purpose: constants shared by the encoder counter bank and its channel module
// Assumes: register indices count 32-bit words; byte address is four times the index
// Notes: definitions only
`ifndef QEC_CONSTS_VH
`define QEC_CONSTS_VH

// register indices, byte address = index * 4
`define QEC_IDX_CAP 6'h00
`define QEC_IDX_LIVE 6'h10
`define QEC_IDX_PRESET 6'h20
`define QEC_IDX_STATUS 6'h0C
`define QEC_IDX_DOUT 6'h2E
`define QEC_IDX_IRQ_STAT 6'h30
`define QEC_IDX_IRQ_MASK 6'h31
`define QEC_IDX_STEP 2

// apb address bits that carry the index
`define QEC_ADDR_W 8
`define QEC_ADDR_IDX_MSB 7
`define QEC_ADDR_IDX_LSB 2

// channel geometry
`define QEC_NCH 6
`define QEC_LAST_CH 5
`define QEC_CNT_W 16
`define QEC_LAST_W 18
`define QEC_LAST_TOP 17

// discrete output register fields
`define QEC_DOUT_CAL_BIT 6
`define QEC_DOUT_EXTRA_BIT 7
`define QEC_DOUT_MASK_LSB 8
`define QEC_DOUT_MASK_MSB 13
`define QEC_DOUT_RESET 16'h0000

// status input register fields
`define QEC_STAT_CAL_BIT 6
`define QEC_STAT_EXTRA_BIT 7
`define QEC_STAT_IDX_LSB 8
`define QEC_STAT_IDX_MSB 13

`endif

//--- rtl/qec_channel.v
// Purpose: one quadrature counter channel with input synchronisers and index edge
// Assumes: phase and index pins are asynchronous to CLK_I
// Notes: counts wrap modulo 2**CNT_W
`timescale 1ns/10ps
`include "qec_consts.vh"

module qec_channel #(
	parameter CNT_W = `QEC_CNT_W
) (
	// clock and reset
	input wire clk_i,
	input wire resetn_i,
	// encoder pins
	input wire phase_a_i,
	input wire phase_b_i,
	input wire index_i,
	// preset
	input wire load_i,
	input wire [CNT_W-1:0] load_val_i,
	// results
	output wire [CNT_W-1:0] count_o,
	output wire index_evt_o
);

////////////////////////////////////////////////////////////////////////////////
// two-stage synchronisers, then one delay stage for edge detection
reg [2:0] meta_reg;
reg [2:0] sync_reg;
reg [2:0] dly_reg;
reg [CNT_W-1:0] count_reg;
reg [CNT_W-1:0] count_next;
wire step;
wire up;

always @(posedge clk_i) begin
	if (!resetn_i) begin
		meta_reg <= 3'h0;
		sync_reg <= 3'h0;
		dly_reg <= 3'h0;
	end else begin
		meta_reg <= {index_i, phase_b_i, phase_a_i};
		sync_reg <= meta_reg;
		dly_reg <= sync_reg;
	end
end

////////////////////////////////////////////////////////////////////////////////
// exactly one phase changed: a valid step; a double change is a lost step and ignored
assign step = sync_reg[0] ^ dly_reg[0] ^ sync_reg[1] ^ dly_reg[1];
// phase a leading phase b counts up
assign up = sync_reg[0] ^ dly_reg[1];

always @* begin
	count_next = count_reg;
	if (load_i) begin
		count_next = load_val_i;
	end else if (step) begin
		if (up) begin
			count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end else begin
			count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
end

always @(posedge clk_i) begin
	if (!resetn_i) begin
		count_reg <= {CNT_W{1'b0}};
	end else begin
		count_reg <= count_next;
	end
end

assign count_o = count_reg;
assign index_evt_o = sync_reg[2] & ~dly_reg[2];

endmodule

//--- rtl/qec_bank.v
// Purpose: six quadrature encoder counters with preset, index latch and apb registers
// Assumes: one 25 MHz clock, synchronous active-low reset, apb master on same clock
// Notes: the last channel keeps two extra bits and reads divided by two
// Notes: register offsets are word indices; the byte address is four times the index
// Notes: encoder pins must hold each level three clocks or a step may be lost
// Notes: a pending index bit clears only by masking and then unmasking its channel
// Notes: the irq status register records every index event, masked or not
// Notes: the discrete output word is write-only; software keeps its own copy
//
// Contract
// - six independent 16-bit quadrature counters, each with own phase pair and index.
// - writing a channel's preset location loads its counter; presets at 20h step two.
// - last channel counts wider internally and reads its count divided by two.
// - host sets extra bit via discrete output bit 7; loaded with the preset.
// - each index pulse latches the count; readable at 00h plus two per channel.
// - index latch updates regardless of mask; status bit goes low only if unmasked.
// - last channel index latch keeps only the divided value, not the extra bit.
// - reading 10h plus two per channel returns that channel's live count.
// - status bits 8-13 read low while pending; cleared by mask low then high.
// - extra-bit status shows counter bit 0 or 17 per board jumper input.
// - latched extra-bit preset value is zero after reset.
`timescale 1ns/10ps
`include "qec_consts.vh"

module qec_bank #(
	parameter NCH = `QEC_NCH
) (
	// clock and reset
	input wire CLK_I,
	input wire RESETN_I,
	// apb slave
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [`QEC_ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output wire PREADY_O,
	output wire [31:0] PRDATA_O,
	output wire PSLVERR_O,
	// encoder pins
	input wire [NCH-1:0] PHASE_A_INPUT_I,
	input wire [NCH-1:0] PHASE_B_INPUT_I,
	input wire [NCH-1:0] INDEX_PULSE_INPUT_I,
	// board configuration: 1 selects counter bit 17, 0 selects bit 0
	input wire EXTRA_BIT_SELECT_JUMPER_I,
	// interrupt
	output wire IRQ_O
);

////////////////////////////////////////////////////////////////////////////////
// declarations
reg pready_reg;
reg pready_next;
reg [31:0] prdata_reg;
reg [31:0] prdata_next;
reg pslverr_reg;
reg pslverr_next;
reg [15:0] dout_reg;
reg [15:0] dout_next;
reg [NCH-1:0] pend_reg;
reg [NCH-1:0] pend_next;
reg [NCH-1:0] irq_stat_reg;
reg [NCH-1:0] irq_stat_next;
reg [NCH-1:0] irq_mask_reg;
reg [NCH-1:0] irq_mask_next;
reg irq_reg;
reg jmp_meta_reg;
reg jmp_sync_reg;
reg rd_ok;
reg wr_ok;
reg [15:0] rd_val;
integer c;

wire [5:0] idx;
wire setup;
wire commit;
wire wr_commit;
wire [NCH-1:0] hit_cap;
wire [NCH-1:0] hit_live;
wire [NCH-1:0] hit_pre;
wire [NCH-1:0] idx_evt;
wire [NCH-1:0] mask;
wire [16*NCH-1:0] live_all;
wire [16*NCH-1:0] cap_all;
wire [`QEC_LAST_W-1:0] last_cnt;
wire extra_stat;
reg [15:0] status_word;
wire hit_status;
wire hit_dout;
wire hit_istat;
wire hit_imask;
wire cal_flag;
wire extra_preset;

////////////////////////////////////////////////////////////////////////////////
// apb decode
// address bits 1:0 are ignored; each register is one aligned word
assign idx = PADDR_I[`QEC_ADDR_IDX_MSB:`QEC_ADDR_IDX_LSB];
assign setup = PSEL_I & ~PENABLE_I;
// a transfer completes only at the edge where pready is seen high
assign commit = PSEL_I & PENABLE_I & pready_reg;
assign wr_commit = commit & PWRITE_I & ~pslverr_reg;

assign hit_status = (idx == `QEC_IDX_STATUS);
assign hit_dout = (idx == `QEC_IDX_DOUT);
assign hit_istat = (idx == `QEC_IDX_IRQ_STAT);
assign hit_imask = (idx == `QEC_IDX_IRQ_MASK);

assign mask = dout_reg[`QEC_DOUT_MASK_MSB:`QEC_DOUT_MASK_LSB];
// named fields of the discrete output word
assign cal_flag = dout_reg[`QEC_DOUT_CAL_BIT];
assign extra_preset = dout_reg[`QEC_DOUT_EXTRA_BIT];

////////////////////////////////////////////////////////////////////////////////
// channels
genvar g;
generate
	for (g = 0; g < NCH; g = g + 1) begin : ch
		localparam integer CAP_I = `QEC_IDX_CAP + `QEC_IDX_STEP * g;
		localparam integer LIVE_I = `QEC_IDX_LIVE + `QEC_IDX_STEP * g;
		localparam integer PRE_I = `QEC_IDX_PRESET + `QEC_IDX_STEP * g;
		localparam [5:0] CAP_IDX = CAP_I[5:0];
		localparam [5:0] LIVE_IDX = LIVE_I[5:0];
		localparam [5:0] PRE_IDX = PRE_I[5:0];
		localparam CW = (g == `QEC_LAST_CH) ? `QEC_LAST_W : `QEC_CNT_W;
		wire [CW-1:0] cnt;
		wire [CW-1:0] load_val;
		wire [15:0] live16;
		reg [15:0] cap_reg;

		assign hit_cap[g] = (idx == CAP_IDX);
		assign hit_live[g] = (idx == LIVE_IDX);
		assign hit_pre[g] = (idx == PRE_IDX);

		// the last channel has a guard bit below and above the 16 bits software sees
		if (g == `QEC_LAST_CH) begin : wide
			// extra bit goes to both bit 0 and bit 17 in the same cycle as the word
			assign load_val = {extra_preset, PWDATA_I[15:0], extra_preset};
			// divide by two: software sees bits 16 down to 1
			assign live16 = cnt[16:1];
			assign last_cnt = cnt;
		end else begin : narrow
			assign load_val = PWDATA_I[15:0];
			assign live16 = cnt;
		end

		qec_channel #(
			.CNT_W(CW)
		) u_chan (
			.clk_i(CLK_I),
			.resetn_i(RESETN_I),
			.phase_a_i(PHASE_A_INPUT_I[g]),
			.phase_b_i(PHASE_B_INPUT_I[g]),
			.index_i(INDEX_PULSE_INPUT_I[g]),
			.load_i(wr_commit & hit_pre[g]),
			.load_val_i(load_val),
			.count_o(cnt),
			.index_evt_o(idx_evt[g])
		);

		// the latch ignores the mask; only the divided value is kept
		// an index in the same cycle as a preset captures the count before the load
		always @(posedge CLK_I) begin
			if (!RESETN_I) begin
				cap_reg <= 16'h0000;
			end else if (idx_evt[g]) begin
				cap_reg <= live16;
			end
		end

		assign live_all[16*g+15:16*g] = live16;
		assign cap_all[16*g+15:16*g] = cap_reg;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// jumper is a board level; synchronise before use
always @(posedge CLK_I) begin
	if (!RESETN_I) begin
		jmp_meta_reg <= 1'b0;
		jmp_sync_reg <= 1'b0;
	end else begin
		jmp_meta_reg <= EXTRA_BIT_SELECT_JUMPER_I;
		jmp_sync_reg <= jmp_meta_reg;
	end
end

assign extra_stat = jmp_sync_reg ? last_cnt[`QEC_LAST_TOP] : last_cnt[0];

// pending index bits read active low; unused status bits read zero
always @* begin
	status_word = 16'h0000;
	status_word[`QEC_STAT_IDX_MSB:`QEC_STAT_IDX_LSB] = ~pend_reg;
	status_word[`QEC_STAT_EXTRA_BIT] = extra_stat;
	status_word[`QEC_STAT_CAL_BIT] = cal_flag;
end

////////////////////////////////////////////////////////////////////////////////
// read mux and access legality, evaluated in the setup cycle
// an index that decodes to nothing leaves rd_ok low and answers with an error
always @* begin
	rd_val = 16'h0000;
	rd_ok = 1'b0;
	wr_ok = 1'b0;
	for (c = 0; c < NCH; c = c + 1) begin
		if (hit_cap[c]) begin
			rd_val = cap_all[16*c +: 16];
			rd_ok = 1'b1;
		end
		if (hit_live[c]) begin
			rd_val = live_all[16*c +: 16];
			rd_ok = 1'b1;
		end
		if (hit_pre[c]) begin
			wr_ok = 1'b1;
		end
	end
	if (hit_status) begin
		rd_val = status_word;
		rd_ok = 1'b1;
	end
	if (hit_dout) begin
		wr_ok = 1'b1;
	end
	if (hit_istat) begin
		rd_val = {10'h000, irq_stat_reg};
		rd_ok = 1'b1;
		wr_ok = 1'b1;
	end
	if (hit_imask) begin
		rd_val = {10'h000, irq_mask_reg};
		rd_ok = 1'b1;
		wr_ok = 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// apb answer: one wait-free access phase, data and error registered in setup
always @* begin
	pready_next = 1'b0;
	prdata_next = prdata_reg;
	pslverr_next = pslverr_reg;
	if (setup) begin
		pready_next = 1'b1;
		// write-only and unmapped locations read as zero with an error
		prdata_next = (PWRITE_I | ~rd_ok) ? 32'h00000000 : {16'h0000, rd_val};
		pslverr_next = PWRITE_I ? ~wr_ok : ~rd_ok;
	end else if (commit) begin
		pslverr_next = 1'b0;
	end else if (PSEL_I & PENABLE_I) begin
		// an access with no setup before it still ends, so the bus cannot hang
		pready_next = 1'b1;
	end
end

always @(posedge CLK_I) begin
	if (!RESETN_I) begin
		pready_reg <= 1'b0;
		prdata_reg <= 32'h00000000;
		pslverr_reg <= 1'b0;
	end else begin
		pready_reg <= pready_next;
		prdata_reg <= prdata_next;
		pslverr_reg <= pslverr_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// discrete output word: extra-bit preset, calibration flag and index masks
// bits outside the named fields are stored but drive nothing
always @* begin
	dout_next = dout_reg;
	if (wr_commit & hit_dout) begin
		dout_next = PWDATA_I[15:0];
	end
end

always @(posedge CLK_I) begin
	if (!RESETN_I) begin
		dout_reg <= `QEC_DOUT_RESET;
	end else begin
		dout_reg <= dout_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// index pending: set while unmasked, forced clear while masked
// a pulse seen while masked never becomes pending, so unmasking clears cleanly
always @* begin
	pend_next = (pend_reg | idx_evt) & mask;
end

always @(posedge CLK_I) begin
	if (!RESETN_I) begin
		pend_reg <= {NCH{1'b0}};
	end else begin
		pend_reg <= pend_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt: sticky per-channel index events, write one to clear, set wins
always @* begin
	irq_stat_next = irq_stat_reg;
	irq_mask_next = irq_mask_reg;
	if (wr_commit & hit_istat) begin
		irq_stat_next = irq_stat_reg & ~PWDATA_I[NCH-1:0];
	end
	irq_stat_next = irq_stat_next | idx_evt;
	if (wr_commit & hit_imask) begin
		irq_mask_next = PWDATA_I[NCH-1:0];
	end
end

always @(posedge CLK_I) begin
	if (!RESETN_I) begin
		irq_stat_reg <= {NCH{1'b0}};
		irq_mask_reg <= {NCH{1'b0}};
	end else begin
		irq_stat_reg <= irq_stat_next;
		irq_mask_reg <= irq_mask_next;
	end
end

// level output from its own flop, so no decode glitch reaches the pin
always @(posedge CLK_I) begin
	if (!RESETN_I) begin
		irq_reg <= 1'b0;
	end else begin
		irq_reg <= |(irq_stat_next & irq_mask_next);
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
assign PREADY_O = pready_reg;
assign PRDATA_O = prdata_reg;
assign PSLVERR_O = pslverr_reg;
assign IRQ_O = irq_reg;

endmodule

//--- test/qec_chk.sv
// Purpose: port checks for the encoder counter bank
// Assumes: apb master keeps the zero-wait contract of the bank
// Notes: bound to qec_bank at the foot of this file
`timescale 1ns/10ps
module qec_chk (
	// clock and reset
	input wire CLK_I,
	input wire RESETN_I,
	// apb
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [7:0] PADDR_I,
	input wire PREADY_O,
	input wire [31:0] PRDATA_O,
	input wire PSLVERR_O,
	// interrupt
	input wire IRQ_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	////////////////////////////////////////////////////////////////
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_access;
		PSEL_I && PENABLE_I;
	endsequence
	property p_rdy;
		s_setup |=> PREADY_O;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_rdy_acc;
		PREADY_O |-> s_access ##1 !PREADY_O;
	endproperty
	a_rdy_acc: assert property (p_rdy_acc) else $error("ready stray");
	property p_hi0;
		PREADY_O |-> PRDATA_O[31:16] == 16'h0000;
	endproperty
	a_hi0: assert property (p_hi0) else $error("upper data set");
	property p_err_q;
		PSLVERR_O |-> PREADY_O;
	endproperty
	a_err_q: assert property (p_err_q) else $error("error w/o ready");
	property p_wo_err;
		s_setup ##0 (!PWRITE_I && PADDR_I >= 8'h80 && PADDR_I <= 8'hA8) |=> PSLVERR_O;
	endproperty
	a_wo_err: assert property (p_wo_err) else $error("preset readable");
	property p_ro_err;
		s_setup ##0 (PWRITE_I && PADDR_I <= 8'h7C) |=> PSLVERR_O;
	endproperty
	a_ro_err: assert property (p_ro_err) else $error("count writable");
	property p_live_ok;
		s_setup ##0 (!PWRITE_I && PADDR_I == 8'h40) |=> !PSLVERR_O;
	endproperty
	a_live_ok: assert property (p_live_ok) else $error("live read refused");
	// read data must not drift between transfers, software may sample late
	property p_hold;
		!PSEL_I || PENABLE_I |=> $stable(PRDATA_O);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rst;
		disable iff (1'b0) !RESETN_I |=> PRDATA_O == 32'h0 && !IRQ_O && !PREADY_O;
	endproperty
	a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule
bind qec_bank qec_chk chk_i (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
	.PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O));

//--- test/qec_enc_model.sv
// Purpose: behavioural shaft encoders for six channels
// Assumes: pins change just after a rising edge
// Notes: steps spaced five clocks so the three-stage input path never drops one
`timescale 1ns/10ps
module qec_enc_model (
	// clock
	input wire clk_i,
	// encoder pins
	output logic [5:0] phase_a_o,
	output logic [5:0] phase_b_o,
	output logic [5:0] index_o
);
	initial begin
		phase_a_o = 6'h00;
		phase_b_o = 6'h00;
		index_o = 6'h00;
	end
	////////////////////////////////////////////////////////////////
	// gray sequence: exactly one phase moves per step, a leads b going up
	task automatic step(input int ch, input bit up);
		logic a;
		a = phase_a_o[ch];
		@(posedge clk_i);
		phase_a_o[ch] <= up ? ~phase_b_o[ch] : phase_b_o[ch];
		phase_b_o[ch] <= up ? a : ~a;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic pulse(input int ch);
		@(posedge clk_i);
		index_o[ch] <= 1'b1;
		repeat (4) @(posedge clk_i);
		index_o[ch] <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

//--- test/tb.sv
// Purpose: self-checking bench for the encoder counter bank
// Assumes: zero-wait apb slave, encoders from qec_enc_model
// Notes: presets run from a row table, index and extra-bit cases by hand
`timescale 1ns/10ps
`define CHK(n, x, g) begin checked++; if ((g) !== (x)) begin miscompares++; \
	$display("Error %s expected %h seen %h", n, x, g); end end
module tb;
	typedef struct {logic [15:0] val; logic [15:0] exp;} qec_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel, penable, pwrite, jumper;
	logic [7:0] paddr;
	logic [31:0] pwdata, q;
	logic e;
	wire pready, pslverr, irq;
	wire [31:0] prdata;
	wire [5:0] pa, pb, pi;
	int miscompares = 0;
	int checked = 0;
	qec_row_t rows [6] = '{'{16'h0000, 16'h0000}, '{16'hFFFF, 16'hFFFF},
		'{16'h8001, 16'h8001}, '{16'h1234, 16'h1234}, '{16'h7FFE, 16'h7FFE},
		'{16'hA5A5, 16'hA5A5}};
	always #20 clk = ~clk;
	qec_bank qec_bank_i (.CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
		.PRDATA_O(prdata), .PSLVERR_O(pslverr), .PHASE_A_INPUT_I(pa), .PHASE_B_INPUT_I(pb),
		.INDEX_PULSE_INPUT_I(pi), .EXTRA_BIT_SELECT_JUMPER_I(jumper), .IRQ_O(irq));
	qec_enc_model qec_enc_model_i (.clk_i(clk), .phase_a_o(pa), .phase_b_o(pb), .index_o(pi));
	////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// called just after a rising edge; request held until pready is seen high at a rising edge
	task apb(input [7:0] a, input w, input [15:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin
			miscompares++;
			wrap_up;
		end
	endtask
	task rd(input [7:0] a, input [15:0] x, input er, input string n);
		apb(a, 1'b0, 16'h0000);
		`CHK(n, {16'h0000, x}, q)
		`CHK(n, er, e)
	endtask
	task irq_chk(input x);
		repeat (2) @(posedge clk);
		`CHK("irq", x, irq)
	endtask
	initial begin
		{psel, penable, pwrite, jumper} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h30, 16'h3F00, 1'b0, "status");
		for (int i = 0; i < 6; i++) begin
			apb(8'(8'h80 + 8 * i), 1'b1, rows[i].val);
			rd(8'(8'h40 + 8 * i), rows[i].exp, 1'b0, "live");
		end
		rd(8'h30, 16'h3F00, 1'b0, "extra");
		apb(8'h80, 1'b1, 16'h0000);
		qec_enc_model_i.step(0, 1'b0);
		rd(8'h40, 16'hFFFF, 1'b0, "down");
		repeat (3) qec_enc_model_i.step(0, 1'b1);
		rd(8'h40, 16'h0002, 1'b0, "up");
		apb(8'hB8, 1'b1, 16'h0100);
		qec_enc_model_i.pulse(0);
		rd(8'h00, 16'h0002, 1'b0, "cap0");
		rd(8'h30, 16'h3E00, 1'b0, "pend");
		irq_chk(1'b0);
		apb(8'hC4, 1'b1, 16'h0001);
		irq_chk(1'b1);
		apb(8'hC0, 1'b1, 16'h0001);
		irq_chk(1'b0);
		apb(8'hB8, 1'b1, 16'h0000);
		apb(8'hB8, 1'b1, 16'h0140);
		rd(8'h30, 16'h3F40, 1'b0, "clear");
		qec_enc_model_i.pulse(1);
		rd(8'h08, 16'hFFFF, 1'b0, "cap1");
		rd(8'h30, 16'h3F40, 1'b0, "masked");
		apb(8'hB8, 1'b1, 16'h0080);
		apb(8'hA8, 1'b1, 16'h0000);
		rd(8'h30, 16'h3F80, 1'b0, "x load");
		qec_enc_model_i.step(5, 1'b1);
		rd(8'h68, 16'h0001, 1'b0, "half");
		rd(8'h30, 16'h3F00, 1'b0, "bit0");
		@(posedge clk);
		jumper <= 1'b1;
		// the jumper passes two flops before the status word sees it
		repeat (2) @(posedge clk);
		rd(8'h30, 16'h3F80, 1'b0, "bit17");
		qec_enc_model_i.pulse(5);
		rd(8'h28, 16'h0001, 1'b0, "cap5");
		rd(8'h80, 16'h0000, 1'b1, "wo");
		rd(8'hFC, 16'h0000, 1'b1, "unmapped");
		apb(8'h40, 1'b1, 16'h0005);
		`CHK("ro", 1'b1, e)
		rd(8'h40, 16'h0002, 1'b0, "kept");
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h40, 16'h0000, 1'b0, "rerst");
		rd(8'h30, 16'h3F00, 1'b0, "rerst");
		wrap_up;
	end
endmodule
